// >>> flash_self_program_pkg.sv
// constants and types for the flash self program controller
//
// Overview of operation
// - data low and high registers form one 14-bit program word for read and write
// - address low and high registers form one 13-bit flash word address
// - 2K words of flash exist, word addresses 0000h through 07FFh
// - reads fetch one word; writes store a group of four words
// - a four-word write erases the addressed row first, then programs
// - an internal timer sets the length of every erase and program step
// - code guard never stops the cpu from reading or writing flash
// - block lock field forbids self writes to some blocks; reads always allowed
// - with code guard on, the serial programming port gets no memory access
// - the address pair can express addresses up to 8K words
// - software can set fetch and store triggers but never clear them
// - hardware clears fetch trigger after read, store trigger after write
// - writes start only while store permit is set
// - store permit is zero after reset
// - unlock register has no storage and always reads zero
// - unlock register serves only in the write sequence
package flash_self_program_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] OFS_DATA_LOW = 3'h0;
    localparam logic [2:0] OFS_DATA_HIGH = 3'h1;
    localparam logic [2:0] OFS_ADDR_LOW = 3'h2;
    localparam logic [2:0] OFS_ADDR_HIGH = 3'h3;
    localparam logic [2:0] OFS_CTRL = 3'h4;
    localparam logic [2:0] OFS_UNLOCK = 3'h5;
    // control register bit positions
    localparam int BIT_FETCH = 0;
    localparam int BIT_STORE = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_REFUSED = 3;
    // widths and memory size
    localparam int DATA_W = 14;
    localparam int ADDR_W = 13;
    localparam int MEM_WORDS = 2048;
    localparam logic [12:0] ADDR_LAST = 13'h07FF;
    localparam int ROW_WORDS = 4;
    // unlock sequence: two bytes written back to back
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    // step times in microseconds and derived cycle counts at 25 MHz
    localparam int CLK_MHZ = 25;
    localparam int ERASE_US = 2;
    localparam int PROG_US = 2;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_LOCK = 2'h0;
    typedef enum logic [2:0] {IDLE, ERASE, PROGRAM, NEXT} seq_state_t;
endpackage

// >>> flash_step_timer.sv
// one-shot timer that measures erase and program steps
`timescale 1ns/1ns
module flash_step_timer (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic start_i,
    input wire logic [7:0] len_i,
    output logic done_o
);
    logic [7:0] cnt_q;
    logic run_q;
    // count down from the loaded length, pulse done on the last cycle
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cnt_q <= 8'h00;
            run_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= len_i;
            run_q <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
                run_q <= 1'b0;
            end
        end
    end
    assign done_o = run_q && (cnt_q == 8'h01);
endmodule // flash_step_timer

// >>> flash_self_program_ctrl.sv
// indirect cpu access controller for on-chip program flash
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module flash_self_program_ctrl (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [1:0] BLOCK_LOCK_I,
    input wire logic CODE_GUARD_I,
    input wire logic SERIAL_REQ_I,
    output logic SERIAL_GRANT_O,
    output logic BUSY_O
);
    ////////////////////////////////////////////////////////////////////////
    // configuration straps through two flops, they come from fuses
    logic [1:0] lock_s1_q, lock_q;
    logic guard_s1_q, guard_q, sreq_s1_q, sreq_q;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lock_s1_q <= flash_self_program_pkg::RST_LOCK;
            lock_q <= flash_self_program_pkg::RST_LOCK;
            guard_s1_q <= 1'b0;
            guard_q <= 1'b0;
            sreq_s1_q <= 1'b0;
            sreq_q <= 1'b0;
        end else begin
            lock_s1_q <= BLOCK_LOCK_I;
            lock_q <= lock_s1_q;
            guard_s1_q <= CODE_GUARD_I;
            guard_q <= guard_s1_q;
            sreq_s1_q <= SERIAL_REQ_I;
            sreq_q <= sreq_s1_q;
        end
    end
    // serial programmer shut out entirely while guarded
    assign SERIAL_GRANT_O = sreq_q && !guard_q;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_dlo = WR_I && (ADDR_I == flash_self_program_pkg::OFS_DATA_LOW);
    wire wr_dhi = WR_I && (ADDR_I == flash_self_program_pkg::OFS_DATA_HIGH);
    wire wr_alo = WR_I && (ADDR_I == flash_self_program_pkg::OFS_ADDR_LOW);
    wire wr_ahi = WR_I && (ADDR_I == flash_self_program_pkg::OFS_ADDR_HIGH);
    wire wr_ctl = WR_I && (ADDR_I == flash_self_program_pkg::OFS_CTRL);
    wire wr_unl = WR_I && (ADDR_I == flash_self_program_pkg::OFS_UNLOCK);

    logic [7:0] dlo_q, alo_q;
    logic [5:0] dhi_q;
    logic [4:0] ahi_q;
    logic fetch_q, store_q, permit_q, refused_q;
    logic [1:0] unl_q;
    flash_self_program_pkg::seq_state_t st_q;
    logic [1:0] idx_q;

    // full word views of the register pairs
    wire [13:0] data_word = {dhi_q, dlo_q};
    wire [12:0] addr_word = {ahi_q, alo_q};
    wire [10:0] mem_idx = addr_word[10:0];
    wire in_range = (addr_word <= flash_self_program_pkg::ADDR_LAST);
    // lock field: 0 none, 1 lower quarter, 2 lower half, 3 all
    wire [1:0] blk = addr_word[10:9];
    wire locked = (lock_q == 2'h3) || ((lock_q == 2'h2) && !blk[1]) ||
        ((lock_q == 2'h1) && (blk == 2'h0));

    ////////////////////////////////////////////////////////////////////////
    // flash array, rows of four words
    logic [13:0] mem [0:flash_self_program_pkg::MEM_WORDS-1];
    logic [13:0] row_buf [0:flash_self_program_pkg::ROW_WORDS-1];

    // store request: set only, gated by permit and unlock pattern
    wire set_fetch = wr_ctl && WDATA_I[flash_self_program_pkg::BIT_FETCH]
        && !store_q && !fetch_q;
    wire store_req = wr_ctl && WDATA_I[flash_self_program_pkg::BIT_STORE] && !store_q;
    wire store_ok = store_req && permit_q && (unl_q == 2'h2) && !fetch_q
        && in_range && !locked;
    wire store_bad = store_req && !store_ok;

    ////////////////////////////////////////////////////////////////////////
    // unlock tracker: pattern only counts if next write is the store trigger
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            unl_q <= 2'h0;
        end else if (wr_unl) begin
            if (WDATA_I == flash_self_program_pkg::UNLOCK_FIRST) begin
                unl_q <= 2'h1;
            end else if (WDATA_I == flash_self_program_pkg::UNLOCK_SECOND && unl_q == 2'h1) begin
                unl_q <= 2'h2;
            end else begin
                unl_q <= 2'h0;
            end
        end else if (WR_I) begin
            unl_q <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer for erase and program steps
    logic tmr_start, tmr_done;
    flash_step_timer u_timer (
        .CLK_I(CLK_I),
        .SRST_I(SRST_I),
        .start_i(tmr_start),
        .len_i(st_q == flash_self_program_pkg::IDLE ? 8'(flash_self_program_pkg::ERASE_CYC)
            : 8'(flash_self_program_pkg::PROG_CYC)),
        .done_o(tmr_done)
    );
    // start erase on accepted store, each program step after erase or prior word
    assign tmr_start = store_ok || (tmr_done && (st_q == flash_self_program_pkg::ERASE ||
        (st_q == flash_self_program_pkg::PROGRAM && idx_q != 2'h3)));

    ////////////////////////////////////////////////////////////////////////
    // write sequencer: erase row, then program four words
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_q <= flash_self_program_pkg::IDLE;
            idx_q <= 2'h0;
        end else begin
            unique case (st_q)
                flash_self_program_pkg::IDLE: begin
                    if (store_ok) begin
                        st_q <= flash_self_program_pkg::ERASE;
                    end
                end
                flash_self_program_pkg::ERASE: begin
                    if (tmr_done) begin
                        st_q <= flash_self_program_pkg::PROGRAM;
                        idx_q <= 2'h0;
                    end
                end
                flash_self_program_pkg::PROGRAM: begin
                    if (tmr_done) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == 2'h3) begin
                            st_q <= flash_self_program_pkg::NEXT;
                        end
                    end
                end
                flash_self_program_pkg::NEXT: begin
                    st_q <= flash_self_program_pkg::IDLE;
                end
                default: st_q <= flash_self_program_pkg::IDLE;
            endcase
        end
    end

    // row buffer loaded when the store is accepted: data word in the addressed slot, current flash words in the other three
    wire [10:0] row_base = {mem_idx[10:2], 2'h0};
    always_ff @(posedge CLK_I) begin
        if (st_q == flash_self_program_pkg::IDLE && store_ok) begin
            for (int i = 0; i < flash_self_program_pkg::ROW_WORDS; i++) begin
                row_buf[i] <= (2'(i) == mem_idx[1:0]) ? data_word : mem[row_base + 11'(i)];
            end
        end
        if (st_q == flash_self_program_pkg::ERASE && tmr_done) begin
            for (int i = 0; i < flash_self_program_pkg::ROW_WORDS; i++) begin
                mem[row_base + 11'(i)] <= 14'h3FFF;
            end
        end else if (st_q == flash_self_program_pkg::PROGRAM && tmr_done) begin
            mem[row_base + 11'(idx_q)] <= row_buf[idx_q];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers and self clearing triggers
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dlo_q <= flash_self_program_pkg::RST_BYTE;
            dhi_q <= 6'h00;
            alo_q <= flash_self_program_pkg::RST_BYTE;
            ahi_q <= 5'h00;
            fetch_q <= 1'b0;
            store_q <= 1'b0;
            permit_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (fetch_q) begin
                // read completes in one cycle, ready for next instruction
                dlo_q <= in_range ? mem[mem_idx][7:0] : 8'h00;
                dhi_q <= in_range ? mem[mem_idx][13:8] : 6'h00;
                fetch_q <= 1'b0;
            end else begin
                if (wr_dlo) begin
                    dlo_q <= WDATA_I;
                end
                if (wr_dhi) begin
                    dhi_q <= WDATA_I[5:0];
                end
            end
            // address frozen while a write runs so the row stays put
            if (wr_alo && !store_q) begin
                alo_q <= WDATA_I;
            end
            if (wr_ahi && !store_q) begin
                ahi_q <= WDATA_I[4:0];
            end
            if (set_fetch) begin
                fetch_q <= 1'b1;
            end
            if (store_ok) begin
                store_q <= 1'b1;
            end else if (st_q == flash_self_program_pkg::NEXT) begin
                store_q <= 1'b0;
            end
            if (wr_ctl) begin
                permit_q <= WDATA_I[flash_self_program_pkg::BIT_PERMIT];
            end
            if (store_bad) begin
                refused_q <= 1'b1;
            end else if (wr_ctl && !WDATA_I[flash_self_program_pkg::BIT_REFUSED]) begin
                refused_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, one cycle latency; unlock location always zero
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        unique case (ADDR_I)
            flash_self_program_pkg::OFS_DATA_LOW: rd_d = dlo_q;
            flash_self_program_pkg::OFS_DATA_HIGH: rd_d = {2'h0, dhi_q};
            flash_self_program_pkg::OFS_ADDR_LOW: rd_d = alo_q;
            flash_self_program_pkg::OFS_ADDR_HIGH: rd_d = {3'h0, ahi_q};
            flash_self_program_pkg::OFS_CTRL: rd_d = {4'h0, refused_q, permit_q, store_q, fetch_q};
            default: rd_d = 8'h00;
        endcase
    end
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= RD_I ? rd_d : 8'h00;
        end
    end
    assign BUSY_O = store_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // write length in core cycles, used by the timing checks
    localparam int WRITE_LEN = flash_self_program_pkg::ERASE_CYC +
        flash_self_program_pkg::ROW_WORDS * flash_self_program_pkg::PROG_CYC;
    localparam int WRITE_END = WRITE_LEN + 1;
    // busy cycle counter; too long a span for a repetition, so counted here
    logic [8:0] busy_cyc_q;
    always_ff @(posedge CLK_I) begin
        if (SRST_I || !store_q) begin
            busy_cyc_q <= 9'h000;
        end else if (busy_cyc_q != 9'h1FF) begin
            busy_cyc_q <= busy_cyc_q + 9'h001;
        end
    end
    // permit bit starts clear
    a_permit_reset: assert property (@(posedge CLK_I)
        SRST_I |=> !permit_q)
        else $error("permit not clear");
    // no permit, no write
    a_no_store_nopermit: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (store_req && !permit_q && !store_q) |=> !store_q)
        else $error("store without permit");
    // unlock location reads as zero
    a_unlock_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (RD_I && ADDR_I == flash_self_program_pkg::OFS_UNLOCK) |=> RDATA_O == 8'h00)
        else $error("unlock read");
    // fetch bit lives one cycle
    a_fetch_clears: assert property (@(posedge CLK_I) disable iff (SRST_I)
        fetch_q |=> !fetch_q)
        else $error("fetch stuck");
    // store bit cannot be dropped early
    a_store_sticky: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (store_q && st_q != flash_self_program_pkg::NEXT) |=> store_q)
        else $error("store dropped");
    // every write ends on its own
    a_store_ends: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $rose(store_q) |-> ##[1:400] !store_q)
        else $error("write too long");
    // guarded part never grants the serial port
    a_serial_guard: assert property (@(posedge CLK_I) disable iff (SRST_I)
        guard_q |-> !SERIAL_GRANT_O)
        else $error("serial access while guarded");
    // accepted store always starts with the erase
    a_erase_first: assert property (@(posedge CLK_I) disable iff (SRST_I)
        store_ok |=> st_q == flash_self_program_pkg::ERASE)
        else $error("no erase");
    // store without the pattern is dropped
    a_need_unlock: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (store_req && unl_q != 2'h2 && !store_q) |=> !store_q)
        else $error("store without unlock");
    // a refused store raises the flag and stays idle
    a_refuse_flag: assert property (@(posedge CLK_I) disable iff (SRST_I)
        store_bad |=> (refused_q && !store_q))
        else $error("refused store not flagged");
    // locked block never written
    a_lock_blocks: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (store_req && locked) |=> !store_q)
        else $error("store into locked block");
    // no write beyond the last word
    a_range_blocks: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (store_req && !in_range) |=> !store_q)
        else $error("store out of range");
    // permit moves only on a control write
    a_permit_steady: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !wr_ctl |=> $stable(permit_q))
        else $error("permit changed");
    // address held while the row is rewritten
    a_addr_frozen: assert property (@(posedge CLK_I) disable iff (SRST_I)
        store_q |=> $stable(addr_word))
        else $error("address moved during write");
    // idle sequencer means store bit cleared
    a_idle_not_busy: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (st_q == flash_self_program_pkg::IDLE) |-> !store_q)
        else $error("busy while idle");
    // erase end leads to the first program step
    a_erase_to_prog: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (st_q == flash_self_program_pkg::ERASE && tmr_done) |=> (st_q == flash_self_program_pkg::PROGRAM && idx_q == 2'h0))
        else $error("erase not followed by program");
    // fourth program step closes the write
    a_last_step: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (st_q == flash_self_program_pkg::PROGRAM && tmr_done && idx_q == 2'h3) |=> (st_q == flash_self_program_pkg::NEXT))
        else $error("row not closed after four words");
    // write still busy after erase and four program steps
    a_write_busy: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $rose(store_q) |-> ##WRITE_LEN store_q)
        else $error("write ended early");
    // store bit cleared right after the last step
    a_write_done: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $rose(store_q) |-> ##WRITE_END !store_q)
        else $error("store bit not cleared");
    // no fetch while a write runs
    a_fetch_busy: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (wr_ctl && WDATA_I[flash_self_program_pkg::BIT_FETCH] && store_q) |=> !fetch_q)
        else $error("fetch during write");
    // grant only on request
    a_grant_req: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !sreq_q |-> !SERIAL_GRANT_O)
        else $error("grant without request");
    // any other write cancels the pattern
    a_unlock_cancel: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (WR_I && !wr_unl) |=> (unl_q == 2'h0))
        else $error("unlock pattern survived");
    // step timer quiet while idle
    a_timer_quiet: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (st_q == flash_self_program_pkg::IDLE) |-> !tmr_done)
        else $error("timer fired while idle");
    // first word of the erased row reads all ones
    a_erase_row: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (st_q == flash_self_program_pkg::ERASE && tmr_done) |=> (mem[row_base] == 14'h3FFF))
        else $error("row not erased");
    // busy never outlasts the timed write
    a_busy_count: assert property (@(posedge CLK_I) disable iff (SRST_I)
        busy_cyc_q <= 9'(WRITE_END))
        else $error("write too long");
endmodule // flash_self_program_ctrl

// >>> flash_array_model.sv
// reference image of the program flash array standing behind the controller
`timescale 1ns/1ns
module flash_array_model;
    // 2K words of 14 bits; words never written stay unknown and are never compared
    logic [13:0] mem [0:2047];

    ////////////////////////////////////////////////////////////////////////////////
    // row write: row is wiped then refilled, so only the addressed word of the four changes
    task automatic store(input logic [12:0] a, input logic [13:0] d);
        mem[a[10:0]] = d;
    endtask
endmodule // flash_array_model

// >>> flash_self_program_ctrl_tb_top.sv
// self-checking bench for the flash self program controller
`timescale 1ns/1ns
module flash_self_program_ctrl_tb_top;
    logic clk, srst, wr, rd, guard, sreq, grant, busy;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [1:0] lock;
    int fails = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // device and reference image
    flash_self_program_ctrl DUT (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .BLOCK_LOCK_I(lock), .CODE_GUARD_I(guard), .SERIAL_REQ_I(sreq),
        .SERIAL_GRANT_O(grant), .BUSY_O(busy));
    flash_array_model model ();

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus cycle; every strobe is rewritten each call so back-to-back cycles need no gap
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic idle;
        bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, output logic [7:0] q);
        bus(1'b0, 1'b1, a, 8'h00);
        rd <= 1'b0;
        #1 q = rdata;
        @(posedge clk);
    endtask

    task automatic set_addr(input logic [12:0] a);
        wreg(flash_self_program_pkg::OFS_ADDR_LOW, a[7:0]);
        wreg(flash_self_program_pkg::OFS_ADDR_HIGH, {3'h0, a[12:8]});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // fetch one word; data are read at once, no polling, to catch a late load
    task automatic fetch(input logic [12:0] a);
        logic [7:0] lo, hi;
        set_addr(a);
        wreg(flash_self_program_pkg::OFS_CTRL, 8'h01);
        idle;
        rreg(flash_self_program_pkg::OFS_DATA_LOW, lo);
        rreg(flash_self_program_pkg::OFS_DATA_HIGH, hi);
        chk("fetched word", 16'({hi[5:0], lo}), 16'(model.mem[a[10:0]]));
        rreg(flash_self_program_pkg::OFS_CTRL, lo);
        chk("ctrl after fetch", 16'(lo), 16'h0000);
    endtask

    // full store sequence; ok says whether the device must accept it
    task automatic store(input logic [12:0] a, input logic [13:0] d, input logic [7:0] ctl, input bit unl,
        input bit ok);
        int n;
        logic [7:0] r;
        int wlen = flash_self_program_pkg::ERASE_CYC +
            flash_self_program_pkg::ROW_WORDS * flash_self_program_pkg::PROG_CYC;
        set_addr(a);
        wreg(flash_self_program_pkg::OFS_DATA_LOW, d[7:0]);
        wreg(flash_self_program_pkg::OFS_DATA_HIGH, {2'h0, d[13:8]});
        // permit taken from the trigger value, so a no-permit case really starts clear
        wreg(flash_self_program_pkg::OFS_CTRL, ctl & 8'h04);
        if (unl) begin
            wreg(flash_self_program_pkg::OFS_UNLOCK, flash_self_program_pkg::UNLOCK_FIRST);
            wreg(flash_self_program_pkg::OFS_UNLOCK, flash_self_program_pkg::UNLOCK_SECOND);
        end
        wreg(flash_self_program_pkg::OFS_CTRL, ctl);
        idle;
        #1 chk("busy after store", 16'(busy), 16'(ok));
        if (ok) begin
            wreg(flash_self_program_pkg::OFS_CTRL, 8'h04);
            idle;
            #1 chk("busy after clear try", 16'(busy), 16'h0001);
            model.store(a, d);
        end
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk);
            #1 n++;
        end
        if (ok) chk("store length", 16'((n + 4 >= wlen) && (n <= wlen)), 16'h0001);
        rreg(flash_self_program_pkg::OFS_CTRL, r);
        chk("ctrl after store", 16'(r), ok ? 16'h0004 : 16'((ctl & 8'h04) | 8'h08));
        if (n >= 1000) begin
            fails++;
            complete_run;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] r;
        chk("busy at reset", 16'(busy), 16'h0000);
        chk("grant at reset", 16'(grant), 16'h0000);
        rreg(flash_self_program_pkg::OFS_CTRL, r);
        chk("ctrl at reset", 16'(r), 16'h0000);
        wreg(flash_self_program_pkg::OFS_UNLOCK, 8'h55);
        rreg(flash_self_program_pkg::OFS_UNLOCK, r);
        chk("unlock readback", 16'(r), 16'h0000);
        rreg(3'h6, r);
        chk("unmapped read", 16'(r), 16'h0000);
    endtask

    // neighbours in one row, then the top word
    task automatic t_store;
        store(13'h0104, 14'h1111, 8'h06, 1'b1, 1'b1);
        store(13'h0105, 14'h2ABC, 8'h06, 1'b1, 1'b1);
        store(13'h07FF, 14'h3FFE, 8'h06, 1'b1, 1'b1);
        fetch(13'h0104);
        fetch(13'h0105);
        fetch(13'h07FF);
    endtask

    task automatic t_refuse;
        store(13'h0105, 14'h0F0F, 8'h02, 1'b1, 1'b0);
        store(13'h0105, 14'h0F0F, 8'h06, 1'b0, 1'b0);
        store(13'h0800, 14'h0F0F, 8'h06, 1'b1, 1'b0);
        fetch(13'h0105);
    endtask

    // highest locked word of each lock setting is refused, reads still pass
    task automatic t_lock;
        for (int lk = 1; lk < 4; lk++) begin
            lock <= 2'(lk);
            repeat (3) @(posedge clk);
            store((13'h0200 << (lk - 1)) - 13'h0001, 14'h0AA5, 8'h06, 1'b1, 1'b0);
            fetch(13'h0104);
        end
        lock <= 2'h1;
        repeat (3) @(posedge clk);
        store(13'h0200, 14'h1234, 8'h06, 1'b1, 1'b1);
        fetch(13'h0200);
        lock <= 2'h0;
    endtask

    task automatic t_guard;
        logic [1:0] gr;
        for (int i = 0; i < 4; i++) begin
            gr = 2'(i);
            guard <= gr[1];
            sreq <= gr[0];
            repeat (4) @(posedge clk);
            #1 chk("serial grant", 16'(grant), 16'(gr[0] & ~gr[1]));
        end
        store(13'h0106, 14'h1357, 8'h06, 1'b1, 1'b1);
        fetch(13'h0106);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset held ten cycles, then every scenario in turn
    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        lock = 2'h0;
        guard = 1'b0;
        sreq = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_store;
        t_refuse;
        t_lock;
        t_guard;
        complete_run;
    end
endmodule // flash_self_program_ctrl_tb_top
